// >>> logic/opp_port.sv
`timescale 1ns/100ps
// How it works
// - select pins choose lock or code access
// - strobe falling edge latches high address
// - port 2 muxes low and high address
// - write strobe commits code and lock writes
// - data byte moves both ways on port 0
// - read strobe controls code and lock reads
// - select low-high reads version byte
// - lock bits on D1,D0; 11 unprotected
module opp_port
    import opp_pkg::*;
#(
    parameter int MEM_D = opp_pkg::MEM_DEPTH,
    parameter logic [31:0] VERSION_WORD = 32'h0000_0000 // arbitrary version bytes
) (
    input wire logic REF_CLK_I,
    input wire logic ARST_N_I,
    input wire logic CLK_EN_I,
    input wire logic ACCESS_SEL_LO_I,
    input wire logic ACCESS_SEL_HI_I,
    input wire logic HIGH_ADDR_LATCH_STROBE_I,
    input wire logic OTP_WRITE_STROBE_N_I,
    input wire logic OTP_READ_STROBE_N_I,
    input wire logic CODE_FETCH_ENABLE_N_I,
    input wire logic EXT_ACCESS_OTP_WRITE_STROBE_VOLTAGE_I,
    input wire logic [opp_pkg::LOW_W-1:0] MUXED_ADDR_LINES_I,
    input wire logic [opp_pkg::DATA_W-1:0] DATA_LINES_I,
    output logic [opp_pkg::DATA_W-1:0] DATA_LINES_O,
    output logic DATA_LINES_OE_O,
    output logic [1:0] LOCK_LEVEL_BITS_O
);
    import opp_pkg::*;

    opp_sync_if sif ();
    assign sif.raw = {DATA_LINES_I, MUXED_ADDR_LINES_I} ;
    // control pins synchronised separately below, same two-flop scheme
    opp_sync u_sync (
        .clk_i(REF_CLK_I),
        .arst_n_i(ARST_N_I),
        .ce_i(CLK_EN_I),
        .bus(sif.dst)
    );
    logic [7:0] addr_s;
    logic [7:0] din_s;
    assign addr_s = sif.synced[7:0];
    assign din_s = sif.synced[15:8];

    logic [6:0] cm_ff;
    logic [6:0] cs_ff;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            // idle strobe levels, so no false strobe edge follows reset
            cm_ff <= CTRL_RESET;
            cs_ff <= CTRL_RESET;
        end else if (CLK_EN_I) begin
            cm_ff <= {EXT_ACCESS_OTP_WRITE_STROBE_VOLTAGE_I, CODE_FETCH_ENABLE_N_I, OTP_READ_STROBE_N_I,
                      OTP_WRITE_STROBE_N_I, HIGH_ADDR_LATCH_STROBE_I, ACCESS_SEL_HI_I, ACCESS_SEL_LO_I};
            cs_ff <= cm_ff;
        end
    end
    logic sel_lo, sel_hi, ale, wr_n, rd_n, fetch_n, vpp;
    assign {vpp, fetch_n, rd_n, wr_n, ale, sel_hi, sel_lo} = cs_ff;

    // reserved selection decodes to no access at all
    opp_mode_t mode;
    always_comb begin
        case ({sel_hi, sel_lo})
            SEL_VERSION: mode = OPP_VERSION;
            SEL_LOCK: mode = OPP_LOCK;
            SEL_CODE: mode = OPP_CODE;
            default: mode = OPP_RESERVED;
        endcase
    end

    // high address captured on the falling strobe edge
    logic ale_d_ff;
    logic [HIGH_W-1:0] high_addr_ff;
    logic wr_d_ff;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ale_d_ff <= 1'b0;
            wr_d_ff <= 1'b1;
            high_addr_ff <= HIGH_ADDR_RESET;
        end else if (CLK_EN_I) begin
            ale_d_ff <= ale;
            wr_d_ff <= wr_n;
            if (ale_d_ff && !ale) begin
                high_addr_ff <= addr_s[HIGH_W-1:0];
            end
        end
    end
    logic [ADDR_W-1:0] full_addr;
    assign full_addr = {high_addr_ff, addr_s};

    // write commits on the rising edge that ends the low write pulse
    logic wr_commit;
    assign wr_commit = !wr_d_ff && wr_n && fetch_n == 1'b0 && vpp;

    // flop storage; a smaller MEM_D trades address range for run time
    logic [DATA_W-1:0] mem_ff [MEM_D];
    logic [1:0] lock_ff;
    for (genvar k = 0; k < MEM_D; k++) begin : g_mem
        always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
                mem_ff[k] <= ERASED_BYTE;
            end else if (CLK_EN_I && wr_commit && mode == OPP_CODE && lock_ff == LOCK_RESET
                         && full_addr == ADDR_W'(k)) begin
                // otp: bits only go from 1 to 0
                mem_ff[k] <= mem_ff[k] & din_s;
            end
        end
    end

    // lock bits, like the array, only clear on writes; reset sets them back to ones
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lock_ff <= LOCK_RESET;
        end else if (CLK_EN_I && wr_commit && mode == OPP_LOCK) begin
            lock_ff <= lock_ff & din_s[1:0];
        end
    end
    assign LOCK_LEVEL_BITS_O = lock_ff;

    // read data and output enable from flops
    logic [DATA_W-1:0] nxt_dout;
    logic nxt_oe;
    always_comb begin
        nxt_dout = DATA_RESET;
        nxt_oe = 1'b0;
        // a low write strobe blocks the read so the pins never fight
        if (!rd_n && wr_n) begin
            case (mode)
                OPP_CODE: begin
                    nxt_oe = 1'b1;
                    // a cleared lock bit D1 (lock 01 or 00) hides code contents
                    nxt_dout = (lock_ff[1] && int'(full_addr) < MEM_D) ? mem_ff[full_addr] : ERASED_BYTE;
                end
                OPP_LOCK: begin
                    nxt_oe = 1'b1;
                    nxt_dout = {6'h00, lock_ff};
                end
                OPP_VERSION: begin
                    nxt_oe = 1'b1;
                    nxt_dout = VERSION_WORD[8*addr_s[1:0] +: 8];
                end
                default: begin
                    nxt_oe = 1'b0;
                end
            endcase
        end
    end
    logic [DATA_W-1:0] dout_ff;
    logic oe_ff;
    always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            dout_ff <= DATA_RESET;
            oe_ff <= 1'b0;
        end else if (CLK_EN_I) begin
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
        end
    end
    assign DATA_LINES_O = dout_ff;
    assign DATA_LINES_OE_O = oe_ff;

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    chk_oe_needs_read: assert property (CLK_EN_I && oe_ff |-> $past(!rd_n))
        else $error("data driven without read strobe");
    chk_oe_off_idle: assert property (CLK_EN_I && $past(CLK_EN_I) && $past(rd_n) |-> !oe_ff)
        else $error("data driven while read strobe idle");
    chk_lock_read_val: assert property (CLK_EN_I && !rd_n && wr_n && mode == OPP_LOCK ##1 CLK_EN_I
        |-> dout_ff == {6'h00, $past(lock_ff)})
        else $error("lock read value wrong");
    chk_lock_only_clear: assert property (CLK_EN_I |=> (lock_ff & ~$past(lock_ff)) == 2'h0)
        else $error("lock bit returned to one");
    chk_high_addr_latch: assert property (CLK_EN_I && ale_d_ff && !ale ##1 CLK_EN_I
        |-> high_addr_ff == $past(addr_s[HIGH_W-1:0]))
        else $error("high address not latched");
    chk_high_addr_hold: assert property (CLK_EN_I && !(ale_d_ff && !ale)
        |=> high_addr_ff == $past(high_addr_ff))
        else $error("high address moved without strobe");
    chk_lock_write_mode: assert property (mode != OPP_LOCK |=> lock_ff == $past(lock_ff))
        else $error("lock written outside lock mode");
    chk_version_read: assert property (CLK_EN_I && !rd_n && wr_n && mode == OPP_VERSION ##1 CLK_EN_I
        |-> oe_ff && dout_ff == $past(VERSION_WORD[8*addr_s[1:0] +: 8]))
        else $error("version byte read wrong");
    // checks below line up each output flop with the edge that loaded it
    chk_oe_on_read: assert property (CLK_EN_I && !rd_n && wr_n && mode != OPP_RESERVED |=> oe_ff)
        else $error("read strobe gave no data drive");
    chk_no_oe_write: assert property (CLK_EN_I && !wr_n |=> !oe_ff)
        else $error("data driven while write strobe low");
    chk_reserved_no_oe: assert property (CLK_EN_I && mode == OPP_RESERVED |=> !oe_ff)
        else $error("data driven in reserved mode");
    chk_code_read_data: assert property (CLK_EN_I && !rd_n && wr_n && mode == OPP_CODE && lock_ff[1]
        && int'(full_addr) < MEM_D |=> dout_ff == $past(mem_ff[full_addr]))
        else $error("code byte read wrong");
    chk_code_masked: assert property (CLK_EN_I && !rd_n && wr_n && mode == OPP_CODE && !lock_ff[1]
        |=> dout_ff == ERASED_BYTE)
        else $error("protected code byte leaked");
    chk_code_write_val: assert property (CLK_EN_I && wr_commit && mode == OPP_CODE && lock_ff == LOCK_RESET
        && int'(full_addr) < MEM_D |=> mem_ff[$past(full_addr)] == ($past(mem_ff[full_addr]) & $past(din_s)))
        else $error("code byte write value wrong");
    chk_code_locked_out: assert property (CLK_EN_I && wr_commit && lock_ff != LOCK_RESET
        && int'(full_addr) < MEM_D |=> mem_ff[$past(full_addr)] == $past(mem_ff[full_addr]))
        else $error("code byte changed while locked");
    chk_lock_write_val: assert property (CLK_EN_I && wr_commit && mode == OPP_LOCK
        |=> lock_ff == ($past(lock_ff) & $past(din_s[1:0])))
        else $error("lock write value wrong");
    chk_commit_needs_vpp: assert property (CLK_EN_I && !vpp |=> lock_ff == $past(lock_ff))
        else $error("lock written without programming voltage");
    // main scenarios of a normal programming run
    cov_code_write: cover property (wr_commit && mode == OPP_CODE);
    cov_lock_write: cover property (wr_commit && mode == OPP_LOCK);
    cov_code_read: cover property (oe_ff && mode == OPP_CODE);
    cov_version_read: cover property (oe_ff && mode == OPP_VERSION);
    cov_locked_write: cover property (wr_commit && mode == OPP_CODE && lock_ff != LOCK_RESET);
endmodule : opp_port

// >>> logic/opp_sync.sv
`timescale 1ns/100ps
module opp_sync (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    opp_sync_if.dst bus
);
    logic [15:0] meta_ff;
    logic [15:0] sync_ff;
    // two flops per pin bit; first stage read only by the second
    for (genvar i = 0; i < 16; i++) begin : g_bit
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                meta_ff[i] <= 1'b0;
                sync_ff[i] <= 1'b0;
            end else if (ce_i) begin
                meta_ff[i] <= bus.raw[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end
    assign bus.synced = sync_ff;
endmodule : opp_sync

// >>> pkg/opp_pkg.sv
package opp_pkg;
    localparam int ADDR_W = 13;
    localparam int LOW_W = 8;
    localparam int HIGH_W = 5;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 8192;
    localparam int VER_DEPTH = 4;
    localparam logic [1:0] SEL_RESERVED = 2'h0;
    localparam logic [1:0] SEL_VERSION = 2'h1;
    localparam logic [1:0] SEL_LOCK = 2'h2;
    localparam logic [1:0] SEL_CODE = 2'h3;
    localparam logic [1:0] LOCK_RESET = 2'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [4:0] HIGH_ADDR_RESET = 5'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [6:0] CTRL_RESET = 7'h18;
    localparam int SYNC_RESET = 0;
    typedef enum logic [1:0] {
        OPP_RESERVED,
        OPP_VERSION,
        OPP_LOCK,
        OPP_CODE
    } opp_mode_t;
endpackage : opp_pkg

// >>> pkg/opp_sync_if.sv
`timescale 1ns/100ps
interface opp_sync_if;
    logic [15:0] raw;
    logic [15:0] synced;
    modport src (output raw, input synced);
    modport dst (input raw, output synced);
endinterface : opp_sync_if

// >>> verification/opp_otp_write_strobe_model.sv
`timescale 1ns/100ps
module opp_otp_write_strobe_model (
    input wire logic clk_i,
    input wire logic [7:0] dat_i,
    input wire logic oe_i,
    output logic sel_lo_o,
    output logic sel_hi_o,
    output logic ale_o,
    output logic wr_n_o,
    output logic rd_n_o,
    output logic fetch_n_o,
    output logic vpp_o,
    output logic [7:0] addr_o,
    output logic [7:0] dat_o,
    output logic dat_oe_o
);
    initial begin
        {sel_hi_o, sel_lo_o, ale_o, dat_oe_o} = 4'h0;
        // basic mode selection state: write strobe and voltage pin low
        {wr_n_o, rd_n_o} = 2'h1;
        fetch_n_o = 1'b0;
        vpp_o = 1'b0;
        addr_o = 8'h00;
        dat_o = 8'h00;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk_i);
    endtask : wt
    // leave mode selection: strobe rises before the voltage pin does
    task automatic enter();
        wt(4);
        wr_n_o = 1'b1;
        wt(4);
        vpp_o = 1'b1;
        wt(4);
    endtask : enter
    task automatic setup(input logic [1:0] sel, input logic [12:0] a);
        ale_o = 1'b0;
        wt(1);
        {sel_hi_o, sel_lo_o} = sel;
        wt(4);
        addr_o = {3'h0, a[12:8]};
        ale_o = 1'b1;
        wt(4);
        ale_o = 1'b0;
        wt(4);
        addr_o = a[7:0];
    endtask : setup
    task automatic write(input logic [1:0] sel, input logic [12:0] a, input logic [7:0] d);
        setup(sel, a);
        dat_o = d;
        dat_oe_o = 1'b1;
        wr_n_o = 1'b0;
        wt(4);
        wr_n_o = 1'b1;
        wt(4);
        dat_oe_o = 1'b0;
        wt(1);
    endtask : write
    task automatic read(input logic [1:0] sel, input logic [12:0] a, output logic [7:0] q, output logic o);
        setup(sel, a);
        rd_n_o = 1'b0;
        wt(5);
        q = dat_i;
        o = oe_i;
        rd_n_o = 1'b1;
        wt(5);
    endtask : read
endmodule : opp_otp_write_strobe_model

// >>> verification/otp_programming_port_tb.sv
`timescale 1ns/100ps
module otp_programming_port_tb;
    import opp_pkg::*;
    logic clk, arst_n, ce, sl, sh, ale, wr_n, rd_n, fn, vpp, poe, doe, o;
    logic [7:0] ad, pd, dout, q;
    logic [7:0] dl;
    logic [1:0] lk;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    // released lines show the inverse so a stale byte cannot pass
    assign dl = doe ? dout : (poe ? pd : ~pd);
    opp_otp_write_strobe_model m (.clk_i(clk), .dat_i(dl), .oe_i(doe), .sel_lo_o(sl), .sel_hi_o(sh), .ale_o(ale),
        .wr_n_o(wr_n), .rd_n_o(rd_n), .fetch_n_o(fn), .vpp_o(vpp), .addr_o(ad), .dat_o(pd), .dat_oe_o(poe));
    opp_port #(.VERSION_WORD(32'h4433_2211)) dut (.REF_CLK_I(clk), .ARST_N_I(arst_n), .CLK_EN_I(ce),
        .ACCESS_SEL_LO_I(sl), .ACCESS_SEL_HI_I(sh), .HIGH_ADDR_LATCH_STROBE_I(ale),
        .OTP_WRITE_STROBE_N_I(wr_n), .OTP_READ_STROBE_N_I(rd_n), .CODE_FETCH_ENABLE_N_I(fn),
        .EXT_ACCESS_OTP_WRITE_STROBE_VOLTAGE_I(vpp), .MUXED_ADDR_LINES_I(ad), .DATA_LINES_I(dl),
        .DATA_LINES_O(dout), .DATA_LINES_OE_O(doe), .LOCK_LEVEL_BITS_O(lk));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : close_out
    always @(posedge clk) begin
        cycles++;
        // a full run takes about 370 cycles
        if (cycles == 2000) begin
            num_errors++;
            close_out();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic t_code();
        m.write(SEL_CODE, 13'h1A5C, 8'hA5);
        m.read(SEL_CODE, 13'h1A5C, q, o);
        chk(q, 8'hA5);
        chk({7'h0, o}, 8'h01);
        chk({7'h0, doe}, 8'h00);
        m.write(SEL_CODE, 13'h1A5C, 8'h0F);
        m.read(SEL_CODE, 13'h1A5C, q, o);
        chk(q, 8'h05);
        m.read(SEL_CODE, 13'h0A5C, q, o);
        chk(q, ERASED_BYTE);
    endtask : t_code
    task automatic t_version();
        m.read(SEL_VERSION, 13'h0002, q, o);
        chk(q, 8'h33);
        m.read(SEL_RESERVED, 13'h0002, q, o);
        chk({7'h0, o}, 8'h00);
    endtask : t_version
    task automatic t_lock();
        m.read(SEL_LOCK, 13'h0000, q, o);
        chk({6'h0, q[1:0]}, 8'h03);
        // a write pulse while the clock enable is low must leave no trace
        ce = 1'b0;
        m.write(SEL_LOCK, 13'h0000, 8'hFC);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        chk({6'h0, lk}, 8'h03);
        m.write(SEL_LOCK, 13'h0000, 8'hFE);
        chk({6'h0, lk}, 8'h02);
        m.write(SEL_CODE, 13'h1A5C, 8'h00);
        m.read(SEL_CODE, 13'h1A5C, q, o);
        chk(q, 8'h05);
        m.write(SEL_LOCK, 13'h0000, 8'hFC);
        m.read(SEL_CODE, 13'h1A5C, q, o);
        chk(q, ERASED_BYTE);
    endtask : t_lock
    task automatic t_reset();
        arst_n = 1'b0;
        @(negedge clk);
        chk({7'h0, doe}, 8'h00);
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk({6'h0, lk}, 8'h03);
        m.read(SEL_CODE, 13'h1A5C, q, o);
        chk(q, ERASED_BYTE);
        chk({7'h0, o}, 8'h01);
    endtask : t_reset
    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        repeat (3) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        m.enter();
        t_code();
        t_version();
        t_lock();
        t_reset();
        close_out();
    end
endmodule : otp_programming_port_tb
